// file: inc/mds_consts.svh
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH

// Register addresses on the special function register bus
`define MDS_ADDR_BYTE0      8'he9
`define MDS_ADDR_BYTE1      8'hea
`define MDS_ADDR_BYTE2      8'heb
`define MDS_ADDR_BYTE3      8'hec
`define MDS_ADDR_BYTE4      8'hed
`define MDS_ADDR_BYTE5      8'hee
`define MDS_ADDR_CTRL       8'hef

// Control and status register layout
`define MDS_CTRL_RESET      8'h00
`define MDS_BIT_ERR         7
`define MDS_BIT_OVF         6
`define MDS_BIT_DIR         5
`define MDS_CNT_MSB         4
`define MDS_OPND_RESET      8'h00

// Execution times in clock cycles
`define MDS_CYC_DIV32       5'd17
`define MDS_CYC_DIV16       5'd9
`define MDS_CYC_MUL         5'd11
`define MDS_CYC_SHIFT_BASE  5'd3
`define MDS_CYC_NORM_BASE   5'd4
`define MDS_MUL_LIMIT       32'h0000ffff
`define MDS_NORM_MAX        5'd31

`endif

// file: inc/mds_pkg.sv
package mds_pkg;

   // Operation chosen by the register write order
   typedef enum logic [2:0] {
      MDS_OP_NONE  = 3'b000,
      MDS_OP_DIV32 = 3'b001,
      MDS_OP_DIV16 = 3'b010,
      MDS_OP_MUL   = 3'b011,
      MDS_OP_SHIFT = 3'b100,
      MDS_OP_NORM  = 3'b101
   } mds_op_t;

   // One special function register bus access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mds_sfr_req_t;

endpackage

// file: logic/mds_arith_coprocessor.sv
`timescale 1ns/1ps
`include "mds_consts.svh"
// Behaviour
// - All arithmetic is unsigned only
// - Results overwrite the operand byte registers
// - Byte 0 write begins every loading sequence
// - Byte 2/3 write selects 32/16 division
// - Order 0,1,4,5 selects 16/16 division
// - Order 0,4,1,5 selects 16x16 multiplication
// - Byte 5 or control write starts execution
// - Runs concurrently, never stalls the processor
// - Div32 17, div16 9, multiply 11 cycles
// - Shift takes 3 to 18 cycles
// - Normalize takes 4 to 19 cycles
// - Quotient, remainder, product placed in fixed bytes
// - Last result read ends the operation
// - Count zero normalizes, nonzero sets shift count
// - Normalize shifts a nonzero value left until top bit set
// - Direction bit: 0 left, 1 right
// - Zeros shifted in at the vacated end
// - Error detection armed by byte 0, disarmed by last read
// - Write during execution sets error; byte 5 or control write restarts, other writes abandon the run
// - Armed operand byte read during execution sets error only
// - Error flag cleared only by control read
// - Overflow on zero divide, big product, normalized input
// - Other operations clear overflow, writes cannot
module mds_arith_coprocessor (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // Special function register bus
   input  wire mds_pkg::mds_sfr_req_t sfr_req,
   output logic [7:0]                 sfr_rdata,
   output logic                       sfr_hit,
   // Status
   output logic                       busy
);
   import mds_pkg::*;

   // Operand and control state
   logic [7:0]  opnd_reg [6];
   logic [7:0]  rdata_reg;
   logic        err_reg;
   logic        ovf_reg;
   logic        dir_reg;
   logic [4:0]  cnt_reg;
   // Sequencing state
   logic        armed_reg;
   logic        wide_reg;
   logic        last1_reg;
   mds_op_t     run_op_reg;
   mds_op_t     done_op_reg;
   logic [4:0]  cyc_reg;
   // Result staged until the run completes
   logic [47:0] res_reg;
   logic        res_ovf_reg;
   logic [4:0]  res_cnt_reg;

   // Bus decode
   logic        wr_hit;
   logic        rd_hit;
   logic        rd_opnd;
   logic        rd_ctrl;
   logic        wr_byte0;
   logic        wr_byte5;
   logic [2:0]  idx;
   logic        wr_opnd;
   logic        wr_ctrl;
   logic        start;
   mds_op_t     start_op;
   logic        commit;
   logic        last_read;
   // Datapath
   logic [31:0] val32;
   logic [15:0] divisor;
   logic [31:0] q32;
   logic [15:0] r32;
   logic [15:0] q16;
   logic [15:0] r16;
   logic [31:0] prod;
   logic [31:0] shifted;
   logic [4:0]  lz;
   logic [47:0] res_next;
   logic        ovf_next;
   logic [4:0]  cnt_next;
   logic [4:0]  cyc_next;
   logic [7:0]  ctrl_image;

   // Address decode of the seven registers
   assign idx     = 3'(sfr_req.addr - `MDS_ADDR_BYTE0);
   assign sfr_hit = (sfr_req.addr >= `MDS_ADDR_BYTE0) && (sfr_req.addr <= `MDS_ADDR_CTRL);
   assign wr_hit  = sfr_req.wr && sfr_hit;
   assign rd_hit  = sfr_req.rd && sfr_hit;
   assign wr_opnd = wr_hit && (sfr_req.addr != `MDS_ADDR_CTRL);
   assign wr_ctrl = wr_hit && (sfr_req.addr == `MDS_ADDR_CTRL);
   assign rd_opnd = rd_hit && (sfr_req.addr != `MDS_ADDR_CTRL);
   assign rd_ctrl = rd_hit && (sfr_req.addr == `MDS_ADDR_CTRL);
   assign wr_byte0 = wr_hit && (sfr_req.addr == `MDS_ADDR_BYTE0);
   assign wr_byte5 = wr_hit && (sfr_req.addr == `MDS_ADDR_BYTE5);
   assign busy    = (run_op_reg != MDS_OP_NONE);
   assign commit  = busy && (cyc_reg == 5'd1) && !wr_hit;

   // Operation chosen at the starting write
   always_comb begin
      start_op = MDS_OP_NONE;
      if (wr_byte5) begin
         if (wide_reg) begin
            start_op = MDS_OP_DIV32;
         end else if (last1_reg) begin
            start_op = MDS_OP_MUL;
         end else begin
            start_op = MDS_OP_DIV16;
         end
      end else if (wr_ctrl) begin
         if (sfr_req.wdata[`MDS_CNT_MSB:0] == 5'd0) begin
            start_op = MDS_OP_NORM;
         end else begin
            start_op = MDS_OP_SHIFT;
         end
      end
   end
   assign start = (start_op != MDS_OP_NONE);

   // Operand views; byte 5 takes the data being written
   always_comb begin
      val32   = {opnd_reg[3], opnd_reg[2], opnd_reg[1], opnd_reg[0]};
      divisor = {opnd_reg[5], opnd_reg[4]};
      if (wr_byte5) begin
         divisor = {sfr_req.wdata, opnd_reg[4]};
      end
   end

   // Unsigned arithmetic, zero divisor guarded
   always_comb begin
      q32  = 32'hffffffff;
      r32  = 16'h0000;
      q16  = 16'hffff;
      r16  = 16'h0000;
      if (divisor != 16'h0000) begin
         q32 = val32 / {16'h0000, divisor};
         r32 = 16'(val32 % {16'h0000, divisor});
         q16 = val32[15:0] / divisor;
         r16 = val32[15:0] % divisor;
      end
   end

   // Full 32-bit product of the two 16-bit factors
   assign prod = {16'h0000, val32[15:0]} * {16'h0000, divisor};

   // Shift with zero fill, direction and count from the written control byte
   always_comb begin
      if (sfr_req.wdata[`MDS_BIT_DIR]) begin
         shifted = val32 >> sfr_req.wdata[`MDS_CNT_MSB:0];
      end else begin
         shifted = val32 << sfr_req.wdata[`MDS_CNT_MSB:0];
      end
   end

   // Leading zero count, an all-zero value counts as 31
   always_comb begin
      lz = `MDS_NORM_MAX;
      for (int i = 0; i < 32; i++) begin
         if (val32[i]) begin
            lz = 5'(31 - i);
         end
      end
   end

   // Result image, overflow and cycle count for the started operation
   always_comb begin
      res_next = {opnd_reg[5], opnd_reg[4], val32};
      ovf_next = 1'b0;
      cnt_next = sfr_req.wdata[`MDS_CNT_MSB:0];
      cyc_next = `MDS_CYC_DIV32;
      unique case (start_op)
         MDS_OP_DIV32: begin
            res_next = {r32, q32};
            ovf_next = (divisor == 16'h0000);
            cyc_next = `MDS_CYC_DIV32;
         end
         MDS_OP_DIV16: begin
            res_next = {r16, val32[31:16], q16};
            ovf_next = (divisor == 16'h0000);
            cyc_next = `MDS_CYC_DIV16;
         end
         MDS_OP_MUL: begin
            res_next = {divisor, prod};
            ovf_next = (prod > `MDS_MUL_LIMIT);
            cyc_next = `MDS_CYC_MUL;
         end
         MDS_OP_SHIFT: begin
            res_next = {opnd_reg[5], opnd_reg[4], shifted};
            cyc_next = 5'(`MDS_CYC_SHIFT_BASE + ((cnt_next - 5'd1) >> 1));
         end
         MDS_OP_NORM: begin
            res_next = {opnd_reg[5], opnd_reg[4], val32 << lz};
            ovf_next = val32[31];
            cnt_next = lz;
            // An already normalized value still takes the base time
            if (lz == 5'd0) begin
               cyc_next = `MDS_CYC_NORM_BASE;
            end else begin
               cyc_next = 5'(`MDS_CYC_NORM_BASE + ((lz - 5'd1) >> 1));
            end
         end
         MDS_OP_NONE: begin
            cyc_next = `MDS_CYC_DIV32;
         end
      endcase
   end

   // Execution timer; a write while busy that starts nothing abandons the run
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         run_op_reg  <= MDS_OP_NONE;
         cyc_reg     <= 5'd0;
         res_reg     <= 48'h0;
         res_ovf_reg <= 1'b0;
         res_cnt_reg <= 5'd0;
      end else if (start) begin
         run_op_reg  <= start_op;
         cyc_reg     <= cyc_next;
         res_reg     <= res_next;
         res_ovf_reg <= ovf_next;
         res_cnt_reg <= cnt_next;
      end else if (wr_hit && busy) begin
         // A write that starts nothing abandons the run
         run_op_reg  <= MDS_OP_NONE;
      end else if (busy) begin
         cyc_reg <= cyc_reg - 5'd1;
         if (cyc_reg == 5'd1) begin
            run_op_reg <= MDS_OP_NONE;
         end
      end
   end

   // Operand byte registers, loaded by writes or by the result
   generate
      for (genvar b = 0; b < 6; b++) begin : g_opnd
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               opnd_reg[b] <= `MDS_OPND_RESET;
            end else if (wr_opnd && idx == 3'(b)) begin
               opnd_reg[b] <= sfr_req.wdata;
            end else if (commit) begin
               opnd_reg[b] <= res_reg[8*b +: 8];
            end
         end
      end
   endgenerate

   // Write order tracking for operation selection
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wide_reg  <= 1'b0;
         last1_reg <= 1'b0;
      end else if (wr_opnd) begin
         unique case (sfr_req.addr)
            `MDS_ADDR_BYTE0: begin
               wide_reg  <= 1'b0;
               last1_reg <= 1'b0;
            end
            `MDS_ADDR_BYTE1: begin
               last1_reg <= 1'b1;
            end
            `MDS_ADDR_BYTE2: begin
               wide_reg  <= 1'b1;
            end
            `MDS_ADDR_BYTE3: begin
               wide_reg  <= 1'b1;
            end
            `MDS_ADDR_BYTE4: begin
               last1_reg <= 1'b0;
            end
            default: begin
               last1_reg <= last1_reg;
            end
         endcase
      end
   end

   // Operation awaiting its final result read
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         done_op_reg <= MDS_OP_NONE;
      end else if (wr_hit) begin
         // Any write opens a new sequence or restarts
         done_op_reg <= MDS_OP_NONE;
      end else if (commit) begin
         done_op_reg <= run_op_reg;
      end else if (last_read) begin
         done_op_reg <= MDS_OP_NONE;
      end
   end

   // Final read: byte 5 after division, byte 3 otherwise
   always_comb begin
      last_read = 1'b0;
      if (rd_hit && !busy) begin
         if (done_op_reg == MDS_OP_DIV32 || done_op_reg == MDS_OP_DIV16) begin
            last_read = (sfr_req.addr == `MDS_ADDR_BYTE5);
         end else if (done_op_reg != MDS_OP_NONE) begin
            last_read = (sfr_req.addr == `MDS_ADDR_BYTE3);
         end
      end
   end

   // Error detection arming
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         armed_reg <= 1'b0;
      end else if (wr_byte0) begin
         armed_reg <= 1'b1;
      end else if (last_read) begin
         armed_reg <= 1'b0;
      end
   end

   // Error flag: set wins over the clearing control read
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         err_reg <= 1'b0;
      end else if (busy && wr_hit) begin
         err_reg <= 1'b1;
      end else if (busy && armed_reg && rd_opnd) begin
         err_reg <= 1'b1;
      end else if (rd_ctrl) begin
         err_reg <= 1'b0;
      end
   end

   // Overflow flag, owned by hardware only
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ovf_reg <= 1'b0;
      end else if (commit) begin
         ovf_reg <= res_ovf_reg;
      end
   end

   // Direction and count fields
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dir_reg <= 1'b0;
         cnt_reg <= 5'd0;
      end else if (wr_ctrl) begin
         dir_reg <= sfr_req.wdata[`MDS_BIT_DIR];
         cnt_reg <= sfr_req.wdata[`MDS_CNT_MSB:0];
      end else if (commit && run_op_reg == MDS_OP_NORM) begin
         cnt_reg <= res_cnt_reg;
      end
   end

   // Control and status image as the processor sees it
   assign ctrl_image = {err_reg, ovf_reg, dir_reg, cnt_reg};

   // Registered read data, zero for unmapped addresses
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata_reg <= 8'h00;
      end else if (rd_hit) begin
         if (rd_ctrl) begin
            rdata_reg <= ctrl_image;
         end else begin
            rdata_reg <= opnd_reg[idx];
         end
      end else if (sfr_req.rd) begin
         rdata_reg <= 8'h00;
      end
   end
   assign sfr_rdata = rdata_reg;

endmodule

// file: sim/mds_cpu_model.sv
`timescale 1ns/1ps
// Processor side of the register bus, one access at a time
module mds_cpu_model (
   // Clock
   input  wire logic            clk,
   // Register bus
   output mds_pkg::mds_sfr_req_t req,
   input  wire logic [7:0]      rdata
);
   import mds_pkg::*;

   // Idle bus at time zero
   initial req = '{1'b0, 1'b0, 8'h00, 8'h00};

   // One write pulse; released lines show scrambled values
   task sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1;
      req = '{1'b0, 1'b0, ~a, ~d};
   endtask

   // One read pulse; data taken once the answering edge has passed
   task sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) #1;
      d = rdata;
      req = '{1'b0, 1'b0, ~a, 8'hff};
   endtask
endmodule

// file: sim/mds_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the arithmetic coprocessor
module mds_asserts (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst_b,
   // Register bus and status
   input wire mds_pkg::mds_sfr_req_t sfr_req,
   input wire logic [7:0]            sfr_rdata,
   input wire logic                  sfr_hit,
   input wire logic                  busy
);
   import mds_pkg::*;
   logic [5:0] run_cnt;
   logic       loaded;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Cycles of one run not cut by a write
   always_ff @(posedge clk) begin
      if (!rst_b || !busy || sfr_req.wr) run_cnt <= 6'h00;
      else run_cnt <= run_cnt + 6'h01;
   end

   // Loading sequence opened by byte 0
   always_ff @(posedge clk) begin
      if (!rst_b) loaded <= 1'b0;
      else if (sfr_req.wr && sfr_req.addr == 8'he9) loaded <= 1'b1;
      else if (sfr_req.wr && sfr_req.addr == 8'hee) loaded <= 1'b0;
   end

   a_ctrl_starts: assert property (sfr_req.wr && sfr_req.addr == 8'hef |=> busy)
      else $error("control write did not start a run");
   a_byte5_starts: assert property (sfr_req.wr && sfr_req.addr == 8'hee && loaded |=> busy)
      else $error("byte 5 write did not start a run");
   a_busy_min: assert property ($rose(busy) ##0 (!sfr_req.wr) [*2] |-> ##1 busy)
      else $error("run shorter than three cycles");
   a_run_bound: assert property (busy |-> run_cnt <= 6'd18)
      else $error("run longer than nineteen cycles");
   a_wr_abandons: assert property (sfr_req.wr && busy && sfr_req.addr inside {[8'he9:8'hed]} |=> !busy)
      else $error("operand write did not abandon the run");
   a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   a_reset_idle: assert property ($rose(rst_b) |-> !busy && sfr_rdata == 8'h00)
      else $error("unit not idle after reset");
   a_hit_decode: assert property (sfr_hit == (sfr_req.addr >= 8'he9 && sfr_req.addr <= 8'hef))
      else $error("register hit decode wrong");
endmodule

// file: sim/mds_arith_coprocessor_tb_top.sv
`timescale 1ns/1ps
module mds_arith_coprocessor_tb_top;
   import mds_pkg::*;
   logic         clk;
   logic         rst_b;
   mds_sfr_req_t sfr_req;
   logic [7:0]   sfr_rdata;
   logic         sfr_hit;
   logic         busy;
   logic [7:0]   bcnt;
   logic [7:0]   rv;
   int           n_mismatch;
   int           n_checks;

   // Design and processor model
   mds_arith_coprocessor dut_u (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
                                .sfr_hit(sfr_hit), .busy(busy));
   mds_cpu_model cpu_u (.clk(clk), .req(sfr_req), .rdata(sfr_rdata));

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Busy cycle counter, cleared while the unit is idle
   always @(posedge clk) bcnt <= (busy === 1'b1) ? bcnt + 8'h01 : 8'h00;

   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task rc(input logic [7:0] a, input logic [7:0] exp);
      cpu_u.sfr_rd(a, rv);
      chk($sformatf("register %h", a), exp, rv);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      cpu_u.sfr_wr(a, d);
   endtask

   // Final write of a sequence; the busy counter restarts from idle
   task st(input logic [7:0] a, input logic [7:0] d);
      wr(a, d);
   endtask

   // Bounded wait for the end of a run, then its length
   task fin(input logic [7:0] n);
      for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk) #1;
      chk("busy at end", 8'h00, {7'h00, busy});
      chk("busy cycles", n, bcnt);
   endtask

   task ld4(input logic [31:0] v);
      for (int i = 0; i < 4; i++) wr(8'he9 + i[7:0], v[8*i +: 8]);
   endtask

   task rd4(input logic [31:0] v);
      for (int i = 0; i < 4; i++) rc(8'he9 + i[7:0], v[8*i +: 8]);
   endtask

   task rd2(input logic [15:0] v);
      rc(8'hed, v[7:0]);
      rc(8'hee, v[15:8]);
   endtask

   // Reset values and an unmapped address
   task t_reset();
      for (int i = 0; i < 7; i++) rc(8'he9 + i[7:0], 8'h00);
      rc(8'he8, 8'h00);
   endtask

   // Long division, division by zero, short division
   task t_div();
      logic [31:0] q;
      q = 32'hdeadbeef / 32'h1234;
      ld4(32'hdeadbeef);
      wr(8'hed, 8'h34);
      st(8'hee, 8'h12);
      fin(8'd17);
      rd4(q);
      rd2(16'(32'hdeadbeef % 32'h1234));
      rc(8'hef, 8'h00);
      wr(8'he9, 8'hbc);
      wr(8'hea, 8'h9a);
      wr(8'hed, 8'h00);
      st(8'hee, 8'h00);
      fin(8'd9);
      rc(8'he9, 8'hff);
      rc(8'hea, 8'hff);
      rc(8'heb, q[23:16]);
      rc(8'hec, q[31:24]);
      rd2(16'h0000);
      rc(8'hef, 8'h40);
      wr(8'he9, 8'hbc);
      wr(8'hea, 8'h9a);
      wr(8'hed, 8'h23);
      st(8'hee, 8'h01);
      fin(8'd9);
      rc(8'he9, 8'h88);
      rc(8'hea, 8'h00);
      rd2(16'h9abc % 16'h0123);
      rc(8'hef, 8'h00);
   endtask

   // Multiplication with a wide product
   task t_mul();
      wr(8'he9, 8'h34);
      wr(8'hed, 8'h56);
      wr(8'hea, 8'h12);
      st(8'hee, 8'h00);
      fin(8'd11);
      rc(8'hed, 8'h56);
      rc(8'hee, 8'h00);
      rd4(32'h1234 * 32'h0056);
      rc(8'hef, 8'h40);
   endtask

   // Read and write in mid-run
   task t_err();
      wr(8'he9, 8'h03);
      wr(8'hed, 8'h05);
      wr(8'hea, 8'h00);
      st(8'hee, 8'h00);
      rc(8'he9, 8'h03);
      fin(8'd11);
      rd4(32'h0000000f);
      rc(8'hef, 8'h80);
      rc(8'hef, 8'h00);
      wr(8'he9, 8'h10);
      wr(8'hea, 8'h00);
      wr(8'hed, 8'h02);
      st(8'hee, 8'h00);
      wr(8'he9, 8'h55);
      chk("busy", 8'h00, {7'h00, busy});
      rc(8'hef, 8'h80);
   endtask

   // Shifts in both directions, shortest and longest counts
   task t_shift();
      logic [5:0] cs [4] = '{6'h01, 6'h3f, 6'h10, 6'h25};
      for (int i = 0; i < 4; i++) begin
         ld4(32'hc3a55a3c);
         st(8'hef, {2'b00, cs[i]});
         fin(8'd3 + ((cs[i][4:0] - 8'd1) >> 1));
         rd4(cs[i][5] ? 32'hc3a55a3c >> cs[i][4:0] : 32'hc3a55a3c << cs[i][4:0]);
         rc(8'hef, {2'b00, cs[i]});
      end
   endtask

   // Normalize of a small value, one already normalized and the longest case
   task t_norm();
      logic [31:0] v [3] = '{32'h00012345, 32'h80000000, 32'h00000001};
      logic [31:0] x;
      logic [4:0]  k;
      for (int i = 0; i < 3; i++) begin
         x = v[i];
         k = 5'd0;
         while (x[31] !== 1'b1) begin
            x = x << 1;
            k++;
         end
         ld4(v[i]);
         st(8'hef, 8'h00);
         fin(k == 5'd0 ? 8'd4 : 8'd4 + ((k - 8'd1) >> 1));
         rd4(x);
         rc(8'hef, {1'b0, v[i][31], 1'b0, k});
      end
   endtask

   // Reset in mid-run abandons the operation and clears the registers
   task t_rst();
      ld4(32'h00000100);
      wr(8'hed, 8'h01);
      st(8'hee, 8'h00);
      rst_b = 1'b0;
      @(posedge clk) #1;
      rst_b = 1'b1;
      chk("busy after reset", 8'h00, {7'h00, busy});
      rc(8'he9, 8'h00);
      rc(8'hef, 8'h00);
   endtask

   task print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_b = 1'b0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      t_reset();
      t_div();
      t_mul();
      t_err();
      t_shift();
      t_norm();
      t_rst();
      print_verdict();
   end

   // Watchdog
   initial begin
      #(50 * 4000);
      n_mismatch++;
      print_verdict();
   end
endmodule

bind mds_arith_coprocessor mds_asserts chk_u (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req),
                                               .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .busy(busy));
